//--- design/tcc_pkg.sv
// Shared constants for the 16-bit capture/compare timer
package tcc_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] IDX_CTRL = 6'h12; // Control byte
  localparam logic [5:0] IDX_STAT = 6'h13; // Flag byte
  localparam logic [5:0] IDX_CAPT_HI = 6'h14; // Capture high byte
  localparam logic [5:0] IDX_CAPT_LO = 6'h15; // Capture low byte
  localparam logic [5:0] IDX_CMP_HI = 6'h16; // Compare high byte
  localparam logic [5:0] IDX_CMP_LO = 6'h17; // Compare low byte
  localparam logic [5:0] IDX_CNT_HI = 6'h18; // Counter high byte
  localparam logic [5:0] IDX_CNT_LO = 6'h19; // Counter low byte
  localparam logic [5:0] IDX_ALT_HI = 6'h1a; // Alternate counter high
  localparam logic [5:0] IDX_ALT_LO = 6'h1b; // Alternate counter low

  // ************************************************************
  // Control and flag bit positions
  // ************************************************************
  localparam int CTL_CAPT_IE = 7; // Capture irq enable
  localparam int CTL_MATCH_IE = 6; // Match irq enable
  localparam int CTL_WRAP_IE = 5; // Wrap irq enable
  localparam int CTL_RUN = 4; // Timer run enable
  localparam int CTL_EDGE = 1; // Capture edge select
  localparam int CTL_LEVEL = 0; // Match pin level
  localparam int FLG_CAPT = 7; // Capture flag
  localparam int FLG_MATCH = 6; // Match flag
  localparam int FLG_WRAP = 5; // Wrap flag

  // ************************************************************
  // Reset values and counting constants
  // ************************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00; // Everything off
  localparam logic [15:0] CNT_PRESET = 16'hfffc; // Counter preset
  localparam logic [15:0] CNT_MAX = 16'hffff; // Value before wrap
  localparam logic [15:0] CNT_ONE = 16'h0001; // Counter step
  localparam logic [1:0] PRE_LAST = 2'h3; // Divide-by-four end
  localparam logic [1:0] PRE_ONE = 2'h1; // Prescaler step
  localparam logic [1:0] PRE_ZERO = 2'h0; // Prescaler start
  localparam logic [7:0] BYTE_ZERO = 8'h00; // Unmapped read data

endpackage

//--- design/tcc_capture_sync.sv
// Capture pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module tcc_capture_sync
  import tcc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  // ************************************************************
  // Three-stage chain
  // ************************************************************
  logic meta; // First stage, read only by second
  logic sync2; // Second stage
  logic sync3; // Third stage
  logic level; // Accepted level
  logic primed; // Level has been taken once
  logic agree; // Second and third stage agree
  logic [2:0] fill; // Stages already holding real pin samples

  assign agree = (sync2 == sync3);
  // Edges only once the chain holds real samples, so a pin that is high
  // at reset does not fake a rising edge against the reset zeros
  assign rise = primed & agree & sync3 & ~level;
  assign fall = primed & agree & ~sync3 & level;

  // Shift chain and accepted level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      level <= 1'b0;
      primed <= 1'b0;
      fill <= 3'h0;
    end else begin
      meta <= pin;
      sync2 <= meta;
      sync3 <= sync2;
      fill <= {fill[1:0], 1'b1};
      // First level taken only from two real samples
      if (agree & fill[2]) begin
        level <= sync3;
        primed <= 1'b1;
      end
    end
  end

endmodule

//--- design/tcc_timer.sv
// 16-bit free-running timer with capture, compare and Wishbone registers
//
// Function
// - Counter steps once every four clocks
// - Counter reads never disturb it; low live
// - High read buffers low byte until low read
// - Alternate counter never clears wrap flag
// - Reset presets counter; counts after run enable
// - Wrap sets flag, optional interrupt
// - Match sets flag, loads pin level
// - Compare bytes free, untouched by hardware/reset
// - Compare high write suspends match until low
// - Capture stores counter plus one
// - Edge select: 1 rising, 0 falling
// - Unblocked capture edge while counting reloads, sets flag
// - Capture high read blocks awake capture until low
// - Capture register read-only, kept through reset
// - Three enables gate the three flags
// - Run enable low holds timer preset
// - Latched level drives the match pin
// - Flag clears: status access, then low byte
// - Runs in wait; interrupt wakes processor
// - Stop halts counter; reset forces preset
// - Stop edge arms capture, shown on wake
`timescale 1ns/10ps
module tcc_timer
  import tcc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic stop_mode,
  input wire logic capture_input_pin,
  output logic match_output_pin,
  output logic irq
);

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic acc; // Access taken this edge
  logic rd; // Read taken
  logic wr; // Write taken with low lane
  logic [5:0] idx; // Register index
  logic [7:0] next_rdata; // Read data byte

  assign acc = cyc_i & stb_i & ~ack_o;
  assign rd = acc & ~we_i;
  assign wr = acc & we_i & sel_i[0];
  assign idx = adr_i[7:2];

  // Per-location strobes
  logic rd_capt_hi; // Capture high read
  logic rd_capt_lo; // Capture low read
  logic wr_cmp_hi; // Compare high write
  logic wr_cmp_lo; // Compare low write
  logic rd_any_hi; // Either counter high read
  logic rd_any_lo; // Either counter low read
  logic acc_stat; // Any status access
  logic acc_capt_lo; // Any capture low access
  logic acc_cmp_lo; // Any compare low access
  logic acc_cnt_lo; // Any primary counter low access

  assign rd_capt_hi = rd & (idx == IDX_CAPT_HI);
  assign rd_capt_lo = rd & (idx == IDX_CAPT_LO);
  assign wr_cmp_hi = wr & (idx == IDX_CMP_HI);
  assign wr_cmp_lo = wr & (idx == IDX_CMP_LO);
  assign rd_any_hi = rd & ((idx == IDX_CNT_HI) | (idx == IDX_ALT_HI));
  assign rd_any_lo = rd & ((idx == IDX_CNT_LO) | (idx == IDX_ALT_LO));
  assign acc_stat = acc & (idx == IDX_STAT);
  assign acc_capt_lo = acc & (idx == IDX_CAPT_LO);
  assign acc_cmp_lo = acc & (idx == IDX_CMP_LO);
  // Alternate location deliberately left out here
  assign acc_cnt_lo = acc & (idx == IDX_CNT_LO);

  // ************************************************************
  // Registers and state
  // ************************************************************
  logic [7:0] control; // Software control byte
  logic [15:0] count; // Free-running counter
  logic [1:0] pre; // Divide-by-four prescaler
  logic [15:0] compare_value; // Compare register, no reset
  logic [15:0] capture_value; // Capture register, no reset
  logic [7:0] low_buf; // Buffered counter low byte
  logic read_seq; // High byte read, low pending
  logic cmp_lock; // Compare suspended after high write
  logic cap_lock; // Capture blocked after high read
  logic capture_flag; // Capture event seen
  logic match_flag; // Compare match seen
  logic wrap_flag; // Counter wrapped
  logic [2:0] clr_arm; // Status seen with flag set
  logic stop_armed; // Capture edge held during stop
  logic [15:0] stop_cap; // Value held during stop
  logic stop_d; // Stop mode last cycle

  // Control fields
  logic run; // Timer run enable
  logic edge_sel; // Capture edge select
  assign run = control[CTL_RUN];
  assign edge_sel = control[CTL_EDGE];

  // ************************************************************
  // Events
  // ************************************************************
  logic tick; // Counter steps this edge
  logic cap_rise; // Filtered rising edge
  logic cap_fall; // Filtered falling edge
  logic cap_edge; // Qualifying capture edge
  logic cap_ev; // Capture taken while awake
  logic match_ev; // Compare match this edge
  logic wrap_ev; // Counter wraps this edge
  logic stop_exit; // Stop left by interrupt
  logic [15:0] cap_next; // Counter plus one

  // Counter frozen in stop, held preset while disabled
  assign tick = run & ~stop_mode & (pre == PRE_LAST);
  assign wrap_ev = tick & (count == CNT_MAX);
  // Compare sampled once per count value, on its first cycle,
  // so a flag clear is not overwritten for three more cycles
  assign match_ev = run & ~stop_mode & ~cmp_lock & (pre == PRE_ZERO) &
                    (count == compare_value);
  assign cap_edge = edge_sel ? cap_rise : cap_fall;
  assign cap_ev = run & ~stop_mode & cap_edge & ~cap_lock;
  // Sync chain already spent three clocks, hence the plus one
  assign cap_next = count + CNT_ONE;
  assign stop_exit = stop_d & ~stop_mode;

  // Pin synchroniser
  tcc_capture_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .pin(capture_input_pin),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  // ************************************************************
  // Read data selection
  // ************************************************************
  always_comb begin
    unique case (idx)
      IDX_CTRL: next_rdata = control;
      IDX_STAT: next_rdata = {capture_flag, match_flag, wrap_flag, 5'h00};
      IDX_CAPT_HI: next_rdata = capture_value[15:8];
      IDX_CAPT_LO: next_rdata = capture_value[7:0];
      IDX_CMP_HI: next_rdata = compare_value[15:8];
      IDX_CMP_LO: next_rdata = compare_value[7:0];
      IDX_CNT_HI, IDX_ALT_HI: next_rdata = count[15:8];
      // Buffered byte completes a pair, else the live count
      IDX_CNT_LO, IDX_ALT_LO: next_rdata = read_seq ? low_buf : count[7:0];
      default: next_rdata = BYTE_ZERO;
    endcase
  end

  // ************************************************************
  // Bus answer
  // ************************************************************
  // One-cycle registered acknowledge, unmapped reads return zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= acc;
      if (rd) begin
        dat_o <= {24'h00_0000, next_rdata};
      end
    end
  end

  // Control byte, cleared by reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control <= CTRL_RESET;
    end else if (wr & (idx == IDX_CTRL)) begin
      control <= dat_i[7:0];
    end
  end

  // ************************************************************
  // Counter and prescaler
  // ************************************************************
  // Reads never touch these; only run enable and stop do
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= CNT_PRESET;
      pre <= PRE_ZERO;
    end else if (!run) begin
      count <= CNT_PRESET;
      pre <= PRE_ZERO;
    end else if (!stop_mode) begin
      pre <= pre + PRE_ONE;
      if (tick) begin
        count <= count + CNT_ONE;
      end
    end
  end

  // Counter read buffer, shared by both locations
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_buf <= BYTE_ZERO;
      read_seq <= 1'b0;
    end else if (rd_any_hi & ~read_seq) begin
      low_buf <= count[7:0];
      read_seq <= 1'b1;
    end else if (rd_any_lo) begin
      read_seq <= 1'b0;
    end
  end

  // ************************************************************
  // Compare register and match pin
  // ************************************************************
  // No reset on purpose: contents survive reset
  always_ff @(posedge clk) begin
    if (wr_cmp_hi) begin
      compare_value[15:8] <= dat_i[7:0];
    end
    if (wr_cmp_lo) begin
      compare_value[7:0] <= dat_i[7:0];
    end
  end

  // Compare suspend and pin level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmp_lock <= 1'b0;
      match_output_pin <= 1'b0;
    end else begin
      if (wr_cmp_hi) begin
        cmp_lock <= 1'b1;
      end else if (wr_cmp_lo) begin
        cmp_lock <= 1'b0;
      end
      if (match_ev) begin
        match_output_pin <= control[CTL_LEVEL];
      end
    end
  end

  // ************************************************************
  // Capture register
  // ************************************************************
  // No reset on purpose: last capture survives reset
  always_ff @(posedge clk) begin
    if (stop_exit & stop_armed) begin
      capture_value <= stop_cap;
    end else if (cap_ev) begin
      capture_value <= cap_next;
    end
  end

  // Capture block and stop-mode arming
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_lock <= 1'b0;
      stop_armed <= 1'b0;
      stop_cap <= CNT_PRESET;
      stop_d <= 1'b0;
    end else begin
      stop_d <= stop_mode;
      if (rd_capt_hi) begin
        cap_lock <= 1'b1;
      end else if (rd_capt_lo) begin
        cap_lock <= 1'b0;
      end
      // Only the first edge in stop is kept, no flag yet
      if (stop_mode & run & cap_edge & ~stop_armed) begin
        stop_armed <= 1'b1;
        stop_cap <= cap_next;
      end else if (stop_exit) begin
        stop_armed <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Flags and two-step clearing
  // ************************************************************
  logic [2:0] flags; // Capture, match, wrap
  logic [2:0] set_ev; // Hardware set pulses
  logic [2:0] lo_acc; // Matching low-byte accesses
  logic [2:0] clr_ev; // Clear pulses
  assign flags = {capture_flag, match_flag, wrap_flag};
  assign set_ev = {cap_ev | (stop_exit & stop_armed), match_ev, wrap_ev};
  assign lo_acc = {acc_capt_lo, acc_cmp_lo, acc_cnt_lo};
  assign clr_ev = clr_arm & flags & lo_acc;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capture_flag <= 1'b0;
      match_flag <= 1'b0;
      wrap_flag <= 1'b0;
      clr_arm <= 3'h0;
    end else begin
      capture_flag <= set_ev[2] | (capture_flag & ~clr_ev[2]);
      match_flag <= set_ev[1] | (match_flag & ~clr_ev[1]);
      wrap_flag <= set_ev[0] | (wrap_flag & ~clr_ev[0]);
      // Arm on status access with the flag set, drop once used
      clr_arm <= (clr_arm & ~clr_ev) | ({3{acc_stat}} & flags);
    end
  end

  // ************************************************************
  // Interrupt request, also the wake source in wait and stop
  // ************************************************************
  assign irq = (capture_flag & control[CTL_CAPT_IE]) |
               (match_flag & control[CTL_MATCH_IE]) |
               (wrap_flag & control[CTL_WRAP_IE]);

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_PRESCALE: assert property (
    $past(run) & run & (count != $past(count)) |-> $past(pre) == PRE_LAST)
    else $error("Counter stepped off the prescaler boundary");

  AST_RUN_OFF: assert property (!run |=> count == CNT_PRESET)
    else $error("Disabled timer left its preset");

  AST_WRAP: assert property (wrap_ev |=> wrap_flag && count == 16'h0000)
    else $error("Wrap did not set the flag");

  AST_ALT_KEEP: assert property (
    acc & wrap_flag & ((idx == IDX_ALT_HI) | (idx == IDX_ALT_LO)) |=> wrap_flag)
    else $error("Alternate counter access cleared the wrap flag");

  AST_MATCH_PIN: assert property (
    match_ev |=> match_flag && match_output_pin == $past(control[CTL_LEVEL]))
    else $error("Match did not load the pin level");

  AST_CMP_LOCK: assert property (cmp_lock |=> !$rose(match_flag))
    else $error("Match taken while compare suspended");

  AST_CAP_VALUE: assert property (
    cap_ev & ~(stop_exit & stop_armed) |=> capture_value == $past(count) + CNT_ONE)
    else $error("Capture value is not counter plus one");

  AST_CAP_LOCK: assert property (cap_lock & ~stop_exit |=> $stable(capture_value))
    else $error("Capture changed while blocked");

  AST_BUF_HOLD: assert property (read_seq & ~rd_any_lo |=> $stable(low_buf))
    else $error("Counter buffer changed during a pair");

  AST_STOP_HALT: assert property (stop_mode & $past(stop_mode) & run |-> $stable(count))
    else $error("Counter moved during stop");

  AST_CLEAR: assert property (
    acc_stat & capture_flag ##[2:8] (acc_capt_lo & ~set_ev[2]) |=> !capture_flag)
    else $error("Capture flag survived its clear sequence");

  COV_WRAP: cover property (wrap_ev ##1 irq);
  COV_MATCH: cover property (match_ev ##[1:8] acc_stat);
  COV_STOP_CAP: cover property (stop_armed ##1 stop_exit);

endmodule

//--- sim/tcc_pin_partner.sv
// Far-side model: capture pin source and match pin observer
`timescale 1ns/10ps
module tcc_pin_partner (
  input wire logic clk,
  input wire logic rstn,
  input wire logic match_output_pin,
  output logic capture_input_pin,
  output logic [7:0] match_toggles
);
  // ************************************************************
  // Capture pin source
  // ************************************************************
  logic last_level; // Match pin level at the previous edge

  // Pin idles low until the bench asks for a level
  initial begin
    capture_input_pin = 1'b0;
  end

  // New level held 8 clocks, so the agreement filter always accepts it
  task automatic set_pin(input logic v);
    @(posedge clk);
    capture_input_pin <= v;
    repeat (8) @(posedge clk);
  endtask

  // ************************************************************
  // Match pin observer
  // ************************************************************
  // Counts level changes; a stuck pin shows as a missing count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_level <= 1'b0;
      match_toggles <= 8'h00;
    end else begin
      last_level <= match_output_pin;
      if (match_output_pin !== last_level) begin
        match_toggles <= match_toggles + 8'h01;
      end
    end
  end
endmodule

//--- sim/tcc_timer_bench.sv
// Self-checking bench for the capture/compare timer
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tcc_timer_bench
  import tcc_pkg::*;
;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clk, rstn, cyc, stb, we, ack, stop_mode, cap_pin, match_pin, irq;
  logic [7:0] adr; // Byte address, index in bits 7:2
  logic [3:0] sel; // Lane 0 carries the byte
  logic [31:0] dat_w, dat_r; // Write data and last read word
  logic [7:0] match_toggles; // Pin changes seen by the partner
  logic [7:0] d, h, lo, l1, l2; // Scratch bytes
  logic [15:0] c; // Expected capture value
  int bad_count, check_count;

  tcc_timer DUT (.clk(clk), .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
    .stop_mode(stop_mode), .capture_input_pin(cap_pin),
    .match_output_pin(match_pin), .irq(irq));
  tcc_pin_partner partner (.clk(clk), .rstn(rstn), .match_output_pin(match_pin),
    .capture_input_pin(cap_pin), .match_toggles(match_toggles));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ************************************************************
  // Bus tasks
  // ************************************************************
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One classic cycle; request held until ack is sampled
  task automatic wb(input logic [5:0] idx, input logic w, input logic [7:0] wd,
                    output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    // Upper lanes carry copies; the block must use lane 0 only
    dat_w <= {wd, wd, wd, wd};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
    rd = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd8(input logic [5:0] idx, output logic [7:0] v);
    wb(idx, 1'b0, 8'h00, v);
  endtask

  task automatic wr8(input logic [5:0] idx, input logic [7:0] v);
    logic [7:0] dummy;
    wb(idx, 1'b1, v, dummy);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    rd8(idx, v);
    `CHK(v, exp)
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Reset state, idle timer holds preset, unmapped read
  task automatic t_reset_values();
    rd_chk(IDX_CTRL, CTRL_RESET);
    rd_chk(IDX_STAT, 8'h00);
    rd_chk(IDX_CNT_HI, CNT_PRESET[15:8]);
    rd_chk(IDX_CNT_LO, CNT_PRESET[7:0]);
    rd_chk(6'h00, BYTE_ZERO);
    // Write without lane 0 is acked but ignored
    @(posedge clk) sel <= 4'he;
    wr8(IDX_CTRL, 8'h12);
    sel <= 4'h1;
    rd_chk(IDX_CTRL, CTRL_RESET);
    repeat (20) @(posedge clk);
    rd_chk(IDX_ALT_LO, CNT_PRESET[7:0]);
    `CHK(dat_r[31:8], 24'h000000)
  endtask

  // Two live low reads 40 clocks apart differ by ten counts
  task automatic t_count_rate();
    wr8(IDX_CTRL, 8'h10);
    rd8(IDX_CNT_LO, l1);
    repeat (37) @(posedge clk);
    rd8(IDX_CNT_LO, l2);
    `CHK(l2 - l1, 8'h0a)
  endtask

  // Buffered low from the first high read; alternate shares the pair
  task automatic t_pair_buffer();
    rd8(IDX_CNT_HI, h);
    repeat (44) @(posedge clk);
    rd8(IDX_ALT_HI, h);
    repeat (47) @(posedge clk);
    rd8(IDX_CNT_LO, l1);
    rd8(IDX_CNT_LO, l2);
    `CHK(l2 - l1, 8'h19)
  endtask

  // Wrap flag, its enable, alternate read keeps it, primary clears it
  task automatic t_wrap_flag();
    rd8(IDX_STAT, d);
    `CHK(d[FLG_WRAP], 1'b1)
    `CHK(irq, 1'b0)
    wr8(IDX_CTRL, 8'h30);
    `CHK(irq, 1'b1)
    rd8(IDX_ALT_LO, d);
    rd8(IDX_STAT, d);
    `CHK(d[FLG_WRAP], 1'b1)
    rd8(IDX_CNT_LO, d);
    rd8(IDX_STAT, d);
    `CHK(d[FLG_WRAP], 1'b0)
    `CHK(irq, 1'b0)
  endtask

  // Match at 0x0010, then a high-only write suspends until low written
  task automatic t_compare();
    wr8(IDX_CTRL, 8'h00);
    wr8(IDX_CMP_HI, 8'h00);
    wr8(IDX_CMP_LO, 8'h10);
    rd_chk(IDX_CMP_HI, 8'h00);
    wr8(IDX_CTRL, 8'h11);
    repeat (120) @(posedge clk);
    rd8(IDX_STAT, d);
    `CHK(d[FLG_MATCH], 1'b1)
    `CHK(match_pin, 1'b1)
    `CHK(match_toggles, 8'h01)
    rd_chk(IDX_CMP_LO, 8'h10);
    rd8(IDX_STAT, d);
    `CHK(d[FLG_MATCH], 1'b0)
    wr8(IDX_CTRL, 8'h00);
    wr8(IDX_CMP_HI, 8'h00);
    wr8(IDX_CTRL, 8'h10);
    repeat (120) @(posedge clk);
    rd8(IDX_STAT, d);
    `CHK(d[FLG_MATCH], 1'b0)
    wr8(IDX_CMP_LO, 8'h40);
    repeat (200) @(posedge clk);
    rd8(IDX_STAT, d);
    `CHK(d[FLG_MATCH], 1'b1)
    `CHK(match_pin, 1'b0)
    `CHK(match_toggles, 8'h02)
  endtask

  // Edge select both ways, reload on every edge, high-read lock
  task automatic t_capture();
    wr8(IDX_CTRL, 8'h12);
    partner.set_pin(1'b1);
    rd8(IDX_STAT, d);
    `CHK(d[FLG_CAPT], 1'b1)
    rd8(IDX_CAPT_LO, d);
    rd8(IDX_STAT, d);
    `CHK(d[FLG_CAPT], 1'b0)
    partner.set_pin(1'b0);
    rd8(IDX_STAT, d);
    `CHK(d[FLG_CAPT], 1'b0)
    wr8(IDX_CTRL, 8'h10);
    partner.set_pin(1'b1);
    rd8(IDX_STAT, d);
    `CHK(d[FLG_CAPT], 1'b0)
    // Captured falls below are 64 then 48 clocks apart: 16 and 12 counts
    partner.set_pin(1'b0);
    rd8(IDX_CAPT_LO, l1);
    rd8(IDX_STAT, d);
    `CHK(d[FLG_CAPT], 1'b1)
    repeat (40) @(posedge clk);
    partner.set_pin(1'b1);
    partner.set_pin(1'b0);
    rd8(IDX_CAPT_LO, l2);
    `CHK(l2 - l1, 8'h10)
    rd8(IDX_CAPT_HI, d);
    partner.set_pin(1'b1);
    partner.set_pin(1'b0);
    rd_chk(IDX_CAPT_LO, l2);
    repeat (3) @(posedge clk);
    partner.set_pin(1'b1);
    partner.set_pin(1'b0);
    rd8(IDX_CAPT_LO, d);
    `CHK(d - l2, 8'h0c)
  endtask

  // Stop freezes the count; an edge in stop shows only after wake
  task automatic t_stop_capture();
    // Capture, match and wrap flags are still set from earlier scenarios
    rd8(IDX_STAT, d);
    rd8(IDX_CAPT_LO, d);
    rd8(IDX_CMP_LO, d);
    rd8(IDX_CNT_LO, d);
    rd_chk(IDX_STAT, 8'h00);
    @(posedge clk) stop_mode <= 1'b1;
    repeat (4) @(posedge clk);
    rd8(IDX_CNT_HI, h);
    rd8(IDX_CNT_LO, lo);
    repeat (20) @(posedge clk);
    rd_chk(IDX_CNT_LO, lo);
    partner.set_pin(1'b1);
    partner.set_pin(1'b0);
    rd_chk(IDX_STAT, 8'h00);
    @(posedge clk) stop_mode <= 1'b0;
    repeat (4) @(posedge clk);
    rd8(IDX_STAT, d);
    `CHK(d[FLG_CAPT], 1'b1)
    c = {h, lo} + 16'h0001;
    rd_chk(IDX_CAPT_HI, c[15:8]);
    rd_chk(IDX_CAPT_LO, c[7:0]);
  endtask

  // Reset in stop: preset count, armed edge lost, data registers kept
  task automatic t_reset_in_stop();
    @(posedge clk) stop_mode <= 1'b1;
    partner.set_pin(1'b1);
    partner.set_pin(1'b0);
    @(posedge clk) rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    stop_mode <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(IDX_STAT, 8'h00);
    rd_chk(IDX_CNT_HI, CNT_PRESET[15:8]);
    rd_chk(IDX_CNT_LO, CNT_PRESET[7:0]);
    rd_chk(IDX_CAPT_HI, c[15:8]);
    rd_chk(IDX_CAPT_LO, c[7:0]);
    rd_chk(IDX_CMP_HI, 8'h00);
    rd_chk(IDX_CMP_LO, 8'h40);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h1;
    dat_w = 32'h00000000;
    stop_mode = 1'b0;
    bad_count = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_reset_values();
    t_count_rate();
    t_pair_buffer();
    t_wrap_flag();
    t_compare();
    t_capture();
    t_stop_capture();
    t_reset_in_stop();
    tally_and_finish();
  end
endmodule
